/* File: hdl/mmt_pkg.sv */
// Constants for the module management two-wire target.
// Assumes a single 10 MHz core clock; the serial clock is sampled, not used as a clock.
package mmt_pkg;
    localparam int          CLK_HZ          = 10_000_000;            // Core clock rate
    localparam int          STRETCH_MAX_US  = 500;                   // Longest clock hold-off
    localparam int          STRETCH_CYC     = STRETCH_MAX_US * (CLK_HZ / 1_000_000);
    localparam int          STRETCH_USE_CYC = 4;                     // Hold-off used after the first read byte loads
    localparam logic [6:0]  DEV_ADDR        = 7'h50;                 // 1010000, A0h for writes
    localparam int          PAGE_BYTES      = 128;                   // One page of memory
    localparam int          MEM_BYTES       = 256;                   // Lower plus one upper page
    localparam logic [7:0]  ID_OFFSET       = 8'h80;                 // Byte 128, first byte of upper page zero
    localparam logic [7:0]  ID_RESET        = 8'h0d;                 // Map generation code, arbitrary value
    localparam logic [7:0]  ADDR_RESET      = 8'h00;                 // Byte counter after reset
    localparam int          FIFO_DEPTH      = 8;                     // Write data buffer depth
    localparam int          FIFO_WIDTH      = 16;                    // Address plus data
    localparam logic [3:0]  BIT_LAST        = 4'h7;                  // Last data bit index
    localparam logic [3:0]  BIT_ACK         = 4'h8;                  // Ninth clock
    localparam logic [3:0]  BIT_ZERO        = 4'h0;
endpackage

/* File: hdl/mmt_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a reset already synchronised.
`timescale 1ns/1ns
module mmt_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];     // Storage
    logic [AW:0]      wr_q;               // Write pointer with wrap bit
    logic [AW:0]      rd_q;               // Read pointer with wrap bit
    logic             full;
    logic             empty;

    // Full when pointers differ only in the wrap bit
    assign full      = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    assign empty     = (wr_q == rd_q);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem_q[rd_q[AW-1:0]];

    // Write side
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
        end else if (in_valid && !full) begin
            wr_q <= wr_q + 1'b1;
        end
    end

    // Storage has no reset; contents are only read when valid
    always_ff @(posedge clk) begin
        if (in_valid && !full) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end

    // Read side
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_q <= '0;
        end else if (out_ready && !empty) begin
            rd_q <= rd_q + 1'b1;
        end
    end
endmodule

/* File: hdl/mmt_target.sv */
// Two-wire management target: address match, select gating, byte counter, memory.
// Assumes SCL/SDA/select/reset pins are asynchronous; the host master drives SCL.
//
// Contract
// - Answer at seven-bit address 1010000
// - Ignore bus entirely while not selected
// - Clock stretch at most 500 us
// - Byte 128 page zero holds map identifier
// - Eight bits MSB first, ninth clock ack
// - Byte counter increments, wraps within page
// - Keep reading while host acknowledges
// - Reset pin holds target logic idle
`timescale 1ns/1ns
module mmt_target
    import mmt_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic nrst,
    input  wire logic module_reset_n,
    input  wire logic module_select_n,
    input  wire logic scl_i,
    output logic      scl_o,
    output logic      scl_oe,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe,
    output logic      busy
);
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WRITE, ST_WACK, ST_READ, ST_RACK} mmt_state_e;

    logic [1:0] rst_sync_q;               // Core reset release
    logic       rst_n;
    logic [1:0] scl_s_q, sda_s_q, sel_s_q, mrst_s_q; // Two-stage synchronisers
    logic       scl_q, sda_q;             // Previous synchronised levels
    logic       scl_rise, scl_fall, start_c, stop_c;
    logic       selected, tgt_rst_n;
    mmt_state_e state_q;
    logic [3:0] bit_q;                    // Bit index in byte
    logic [7:0] shift_q;                  // Serial shift register
    logic [7:0] addr_q;                   // Byte address counter
    logic       have_addr_q;              // First written byte was the offset
    logic       sda_low_q;                // Target pulls SDA low
    logic       ack_ok_q;                 // Last write byte acknowledged
    logic [31:0] stretch_q;               // Hold-off counter
    logic [7:0] mem_q [MEM_BYTES];        // Management memory
    logic [15:0] fifo_in, fifo_out;
    logic       fifo_in_valid, fifo_in_ready, fifo_out_valid;

    // Next address wraps within its 128-byte page
    function automatic logic [7:0] next_addr(input logic [7:0] a);
        next_addr = {a[7], a[6:0] + 7'h01};
    endfunction

    // Core reset synchroniser
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) rst_sync_q <= 2'h0;
        else       rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // Pin synchronisers; first stage feeds only the second
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_s_q  <= 2'h3;
            sda_s_q  <= 2'h3;
            sel_s_q  <= 2'h3;
            mrst_s_q <= 2'h0;
        end else begin
            scl_s_q  <= {scl_s_q[0], scl_i};
            sda_s_q  <= {sda_s_q[0], sda_i};
            sel_s_q  <= {sel_s_q[0], module_select_n};
            mrst_s_q <= {mrst_s_q[0], module_reset_n};
        end
    end

    // Edge history
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_s_q[1];
            sda_q <= sda_s_q[1];
        end
    end

    assign scl_rise  = scl_s_q[1] && !scl_q;
    assign scl_fall  = !scl_s_q[1] && scl_q;
    assign start_c   = scl_s_q[1] && scl_q && sda_q && !sda_s_q[1];
    assign stop_c    = scl_s_q[1] && scl_q && !sda_q && sda_s_q[1];
    assign selected  = !sel_s_q[1];
    assign tgt_rst_n = mrst_s_q[1];

    // Protocol engine; a deselect or reset pin abandons any transfer
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q     <= ST_IDLE;
            bit_q       <= BIT_ZERO;
            shift_q     <= 8'h00;
            addr_q      <= ADDR_RESET;
            have_addr_q <= 1'b0;
            sda_low_q   <= 1'b0;
            ack_ok_q    <= 1'b0;
        end else if (!tgt_rst_n || !selected) begin
            state_q   <= ST_IDLE;
            sda_low_q <= 1'b0;
            bit_q     <= BIT_ZERO;
        end else if (start_c) begin
            state_q     <= ST_ADDR;       // Repeated START aborts dummy write, counter kept
            bit_q       <= BIT_ZERO;
            sda_low_q   <= 1'b0;
            have_addr_q <= 1'b0;
        end else if (stop_c) begin
            state_q   <= ST_IDLE;
            sda_low_q <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    sda_low_q <= 1'b0;
                end
                ST_ADDR, ST_WRITE: begin
                    // Sample on rising SCL, MSB first
                    if (scl_rise) begin
                        shift_q <= {shift_q[6:0], sda_s_q[1]};
                        bit_q   <= bit_q + 4'h1;
                    end else if (scl_fall && bit_q == BIT_ACK) begin
                        bit_q <= BIT_ZERO;
                        if (state_q == ST_ADDR) begin
                            if (shift_q[7:1] == DEV_ADDR) begin
                                sda_low_q <= 1'b1;
                                state_q   <= ST_ADDR_ACK;
                            end else begin
                                state_q <= ST_IDLE;   // Not ours: stay silent
                            end
                        end else begin
                            sda_low_q <= fifo_in_ready; // Nack when buffer full
                            ack_ok_q  <= fifo_in_ready;
                            state_q   <= ST_WACK;
                            if (!have_addr_q) begin
                                addr_q      <= shift_q;
                                have_addr_q <= 1'b1;
                            end else if (fifo_in_ready) begin
                                addr_q <= next_addr(addr_q);
                            end
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    // On falling edge of ninth clock release ack for a write, drive first data bit for a read
                    if (scl_fall) begin
                        if (shift_q[0]) begin
                            state_q   <= ST_READ;
                            shift_q   <= mem_q[addr_q];
                            sda_low_q <= !mem_q[addr_q][7];
                            addr_q    <= next_addr(addr_q);
                        end else begin
                            state_q   <= ST_WRITE;
                            sda_low_q <= 1'b0;
                        end
                    end
                end
                ST_WACK: begin
                    if (scl_fall) begin
                        sda_low_q <= 1'b0;
                        state_q   <= ack_ok_q ? ST_WRITE : ST_IDLE;
                    end
                end
                ST_READ: begin
                    // Shift out on falling SCL
                    if (scl_fall) begin
                        if (bit_q == BIT_LAST) begin
                            sda_low_q <= 1'b0;        // Release for host ack
                            bit_q     <= BIT_ZERO;
                            state_q   <= ST_RACK;
                        end else begin
                            shift_q   <= {shift_q[6:0], 1'b0};
                            sda_low_q <= !shift_q[6];
                            bit_q     <= bit_q + 4'h1;
                        end
                    end
                end
                ST_RACK: begin
                    // Host ack sampled on ninth rise; ack continues, nack goes idle, on ninth fall
                    if (scl_rise) begin
                        ack_ok_q <= !sda_s_q[1];
                    end else if (scl_fall) begin
                        if (ack_ok_q) begin
                            state_q   <= ST_READ;
                            shift_q   <= mem_q[addr_q];
                            sda_low_q <= !mem_q[addr_q][7];
                            addr_q    <= next_addr(addr_q);
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Write bytes queue through the buffer before reaching memory
    assign fifo_in       = {addr_q, shift_q};
    assign fifo_in_valid = (state_q == ST_WRITE) && scl_fall && (bit_q == BIT_ACK) && have_addr_q && selected && tgt_rst_n;

    mmt_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk       (core_clk),
        .rst_n     (rst_n),
        .in_data   (fifo_in),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out),
        .out_valid (fifo_out_valid),
        .out_ready (1'b1)
    );

    // Memory update; identifier byte is fixed at reset and read only
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < MEM_BYTES; i++) mem_q[i] <= 8'h00;
            mem_q[ID_OFFSET] <= ID_RESET;
        end else if (fifo_out_valid && fifo_out[15:8] != ID_OFFSET) begin
            mem_q[fifo_out[15:8]] <= fifo_out[7:0];
        end
    end

    // Short hold-off after the first read byte is loaded, well below the limit
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stretch_q <= 32'h0;
        end else if (!selected || !tgt_rst_n) begin
            stretch_q <= 32'h0;
        end else if (state_q == ST_ADDR_ACK && scl_fall && shift_q[0]) begin
            stretch_q <= 32'(STRETCH_USE_CYC);
        end else if (stretch_q != 32'h0) begin
            stretch_q <= stretch_q - 32'h1;
        end
    end

    assign scl_o  = 1'b0;
    assign scl_oe = (stretch_q != 32'h0) && (stretch_q <= 32'(STRETCH_CYC));
    assign sda_o  = 1'b0;
    assign sda_oe = sda_low_q;
    assign busy   = (state_q != ST_IDLE);
endmodule

/* File: tb/mmt_target_asserts.sv */
// Checker for the two-wire target pins.
// Assumes it is bound to mmt_target and sees only its ports.
`timescale 1ns/1ns
module mmt_target_asserts
    import mmt_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic module_reset_n,
    input wire logic module_select_n,
    input wire logic scl_i,
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic busy
);
    int hold_q; // Cycles the target has held SCL low so far

    // Length of the current clock hold-off, cleared when released
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            hold_q <= 0;
        end else begin
            hold_q <= scl_oe ? hold_q + 1 : 0;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);

    // Pin held long enough to pass its two-flop synchroniser
    sequence desel_s;
        module_select_n [*6];
    endsequence
    sequence unreset_s;
        !module_reset_n [*6];
    endsequence
    // A driven bit stays on the wire for at least half its bit time
    sequence bit_held_s;
        sda_oe [*4];
    endsequence

    idle_desel_a: assert property (desel_s |-> !sda_oe && !scl_oe)
        else $error("target drives while deselected");
    idle_reset_a: assert property (unreset_s |-> !sda_oe && !busy)
        else $error("target active while reset pin low");
    abort_idle_a: assert property ($rose(module_select_n) |-> ##[1:8] !busy)
        else $error("no return to idle after deselect");
    stretch_max_a: assert property (hold_q < STRETCH_CYC)
        else $error("clock hold-off too long");
    open_drain_a: assert property (sda_o == 1'b0 && scl_o == 1'b0)
        else $error("pin driven high");
    sda_edge_a: assert property ($changed(sda_oe) && module_reset_n && !module_select_n |-> !scl_i)
        else $error("data moved while clock high");
    drive_busy_a: assert property (sda_oe || scl_oe |-> busy)
        else $error("drive outside a transfer");
    bit_hold_a: assert property ($rose(sda_oe) |-> bit_held_s)
        else $error("driven bit cut short");
endmodule

bind mmt_target mmt_target_asserts mmt_target_asserts_i (
    .core_clk(core_clk), .nrst(nrst), .module_reset_n(module_reset_n), .module_select_n(module_select_n),
    .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .busy(busy));

/* File: tb/mmt_host.sv */
// Host bus master model: pulls SCL and SDA low, never drives them high.
// Assumes the bench forms the pulled-up wire levels and feeds them back.
`timescale 1ns/1ns
module mmt_host
    import mmt_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_pull,
    output logic      sda_pull
);
    int hang = 0; // Hold-offs that ran past the limit

    // Bus idle: both lines released
    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end
    // Every move lands just after a rising edge
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic pin(input logic s, input logic c, input int n);
        sda_pull = s;
        scl_pull = c;
        cyc(n);
    endtask
    // One bit: 4 cycles low, 4 high; a stretch only lengthens the low phase
    task automatic bit_x(input logic d, output logic q);
        int k;
        sda_pull = !d; // SCL is already low on entry
        cyc(4);
        scl_pull = 1'b0;
        #1; // Let the wire settle so a hold-off is seen at once
        for (k = 0; k < STRETCH_CYC && !scl; k++) begin
            cyc(1);
        end
        hang += !scl;
        cyc(4);
        q = sda;
        scl_pull = 1'b1;
    endtask
    // Start or repeated start: SDA falls while SCL is high
    task automatic start();
        sda_pull = 1'b0; // Release SDA, SCL stays as it is
        cyc(4);
        pin(1'b0, 1'b0, 4);
        pin(1'b1, 1'b0, 4);
        scl_pull = 1'b1;
    endtask
    // Stop, then the bus stays free well past the idle minimum
    task automatic stop();
        sda_pull = 1'b1; // SCL is already low here
        cyc(4);
        pin(1'b1, 1'b0, 4);
        pin(1'b0, 1'b0, 210);
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic q;
        for (int i = 7; i >= 0; i--) begin
            bit_x(b[i], q);
        end
        bit_x(1'b1, q);
        ack = !q;
    endtask
    // Host acknowledge asks for one more byte
    task automatic rbyte(input logic more, output logic [7:0] b);
        logic q;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, q);
            b[i] = q;
        end
        bit_x(!more, q);
    endtask
endmodule

/* File: tb/mmt_target_tb.sv */
// Bench for the two-wire target driven by the host master model.
// Assumes the checker binds itself to the target from its own file.
`timescale 1ns/1ns
module mmt_target_tb
    import mmt_pkg::*;
;
    logic       core_clk = 1'b0;
    logic       nrst     = 1'b0;
    logic       mrst_n   = 1'b1; // Module reset pin, released
    logic       msel_n   = 1'b1; // Module select pin, deselected
    logic       scl_pull, sda_pull, scl_oe, sda_oe, busy, a;
    logic [7:0] d0, d1;
    wire        scl      = !(scl_pull || scl_oe); // Pulled-up wires
    wire        sda      = !(sda_pull || sda_oe);
    int         n_fail   = 0;
    int         n_tests  = 0;
    int         n_cyc    = 0; // Cycles run, bounds the whole run

    initial begin
        forever #50 core_clk = !core_clk;
    end
    mmt_target mmt_target_i (.core_clk(core_clk), .nrst(nrst), .module_reset_n(mrst_n), .module_select_n(msel_n),
        .scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe), .busy(busy));
    mmt_host mmt_host_i (.core_clk(core_clk), .scl(scl), .sda(sda), .scl_pull(scl_pull), .sda_pull(sda_pull));

    task automatic chk_b(input string n, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_f(input string n, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %b seen %b", n, e, g);
        end
    endtask
    // A hold-off that ran out in the host counts as a mismatch
    task automatic end_sim();
        n_fail += mmt_host_i.hang;
        if (n_fail == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Watchdog: a hold-off that ran out or a run past its cycle budget ends the run
    always @(posedge core_clk) begin
        n_cyc++;
        if (mmt_host_i.hang != 0 || n_cyc > 90000) begin
            n_fail++;
            end_sim();
        end
    end
    // Select, then wait out the 2 ms setup before any start
    task automatic sel();
        msel_n = 1'b0;
        mmt_host_i.cyc(20010);
    endtask
    task automatic wr(input logic [7:0] off, input logic [7:0] v0, input logic [7:0] v1);
        mmt_host_i.start();
        mmt_host_i.wbyte({DEV_ADDR, 1'b0}, a);
        chk_f("address ack", 1'b1, a);
        mmt_host_i.wbyte(off, a);
        mmt_host_i.wbyte(v0, a);
        mmt_host_i.wbyte(v1, a);
        chk_f("data ack", 1'b1, a);
        mmt_host_i.stop();
    endtask
    // Dummy write of the offset, repeated start, two sequential reads
    task automatic rd(input logic [7:0] off);
        mmt_host_i.start();
        mmt_host_i.wbyte({DEV_ADDR, 1'b0}, a);
        mmt_host_i.wbyte(off, a);
        mmt_host_i.start();
        mmt_host_i.wbyte({DEV_ADDR, 1'b1}, a);
        mmt_host_i.rbyte(1'b1, d0);
        mmt_host_i.rbyte(1'b0, d1);
        mmt_host_i.stop();
    endtask
    // Writes and reads across the page end fold back to its first byte
    task automatic t_wrap();
        wr(8'h7f, 8'h11, 8'h22);
        rd(8'h7f);
        chk_b("byte 7f", 8'h11, d0);
        chk_b("byte 00", 8'h22, d1);
        wr(ID_OFFSET, 8'h5a, 8'h5b);
        rd(ID_OFFSET);
        chk_b("map id", ID_RESET, d0);
        chk_b("byte 81", 8'h5b, d1);
    endtask
    // Wrong address, reset pin low, deselected: never acknowledged
    task automatic t_nack();
        for (int i = 0; i < 3; i++) begin
            mrst_n = (i != 1);
            msel_n = (i == 2);
            mmt_host_i.cyc(20);
            mmt_host_i.start();
            mmt_host_i.wbyte(i == 0 ? 8'ha2 : {DEV_ADDR, 1'b0}, a);
            mmt_host_i.stop();
            chk_f("refused ack", 1'b0, a);
        end
        mrst_n = 1'b1;
        sel();
    endtask
    // Deselect with SCL held low after the address, then a clean read
    task automatic t_abort();
        mmt_host_i.start();
        mmt_host_i.wbyte({DEV_ADDR, 1'b0}, a);
        chk_f("busy in transfer", 1'b1, busy);
        msel_n = 1'b1;
        mmt_host_i.cyc(10);
        chk_f("busy after deselect", 1'b0, busy);
        mmt_host_i.stop();
        sel();
        rd(8'h7f);
        chk_b("byte 7f again", 8'h11, d0);
    endtask

    // Reset for 10 cycles, then the scenarios in turn
    initial begin
        mmt_host_i.cyc(10);
        nrst = 1'b1;
        sel();
        t_wrap();
        t_nack();
        t_abort();
        end_sim();
    end
endmodule
